// file: rtl/fam_datapath.sv
// Float add/multiply datapath with integer add/multiply, one result per clock except multiply ops in the hold after a reciprocal approximation
// Assumes issue logic holds operands with issue_valid and honours issue_ready
`timescale 1ns/10ps

module fam_datapath import fam_pkg::*; #(
	parameter int IDX_W = RCP_IDX_W
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Issue
	input wire logic issue_valid,
	input wire fam_op_e issue_op,
	input wire logic [FP_W-1:0] opnd_a,
	input wire logic [FP_W-1:0] opnd_b,
	output logic issue_ready,
	// Mode
	input wire logic range_err_en,
	// Result
	output logic result_valid,
	output logic [FP_W-1:0] result,
	output logic range_err
);

	localparam int MK = COEF_W + MUL_GUARD;

	function automatic logic [6:0] fam_lzc48(input logic [47:0] v);
		logic [6:0] n;
		logic hit;
		n = 7'h30;
		hit = 1'b0;
		for (int i = 47; i >= 0; i--) begin
			if (v[i] && !hit) begin
				n = 7'(47 - i);
				hit = 1'b1;
			end
		end
		return n;
	endfunction : fam_lzc48

	function automatic logic signed [17:0] e18(input logic [14:0] e);
		return $signed({3'h0, e});
	endfunction : e18

	logic [FP_W-1:0] result_reg;
	logic [FP_W-1:0] result_next;
	logic valid_reg;
	logic err_reg;
	logic err_next;
	logic [2:0] resv_reg;
	logic [2:0] resv_next;

	// Operand fields
	wire sa = opnd_a[SIGN_POS];
	wire sb = opnd_b[SIGN_POS];
	wire [14:0] ea = opnd_a[EXP_LSB +: EXP_W];
	wire [14:0] eb = opnd_b[EXP_LSB +: EXP_W];
	wire [47:0] ca = opnd_a[COEF_W-1:0];
	wire [47:0] cb = opnd_b[COEF_W-1:0];
	wire a_ovf = ea >= EXP_OVF;
	wire b_ovf = eb >= EXP_OVF;
	wire a_unf = ea < EXP_UNF;
	wire b_unf = eb < EXP_UNF;

	// Integer units
	wire [31:0] ia32 = opnd_a[INT_NARROW_W-1:0] + opnd_b[INT_NARROW_W-1:0];
	wire [31:0] is32 = opnd_a[INT_NARROW_W-1:0] - opnd_b[INT_NARROW_W-1:0];
	wire [31:0] im32 = opnd_a[INT_NARROW_W-1:0] * opnd_b[INT_NARROW_W-1:0];
	wire [63:0] ia64 = opnd_a[INT_W-1:0] + opnd_b[INT_W-1:0];
	wire [63:0] is64 = opnd_a[INT_W-1:0] - opnd_b[INT_W-1:0];

	// Adder: underflowed operands count as zero
	wire sb_eff = sb ^ (issue_op == FAM_OP_FSUB);
	wire [14:0] eaz = a_unf ? 15'h0 : ea;
	wire [14:0] ebz = b_unf ? 15'h0 : eb;
	wire [47:0] caz = a_unf ? 48'h0 : ca;
	wire [47:0] cbz = b_unf ? 48'h0 : cb;
	wire a_big = eaz >= ebz;
	wire [14:0] e_hi = a_big ? eaz : ebz;
	wire [14:0] e_diff = a_big ? eaz - ebz : ebz - eaz;
	wire [47:0] c_hi = a_big ? caz : cbz;
	wire [47:0] c_lo_raw = a_big ? cbz : caz;
	wire s_hi = a_big ? sa : sb_eff;
	wire s_lo = a_big ? sb_eff : sa;

	// Align smaller operand, last bit shifted out rounds it up
	wire [48:0] lo_ext = {c_lo_raw, 1'b0} >> e_diff;
	wire [47:0] c_lo = lo_ext[48:1] + {47'h0, lo_ext[0]};

	// Signed-magnitude sum or difference
	wire same_sign = s_hi == s_lo;
	wire lo_gt = c_lo > c_hi;
	wire [48:0] sum_mag = {1'b0, c_hi} + {1'b0, c_lo};
	wire [47:0] dif_mag = lo_gt ? c_lo - c_hi : c_hi - c_lo;
	wire [48:0] add_mag = same_sign ? sum_mag : {1'b0, dif_mag};
	wire add_s = same_sign ? s_hi : (lo_gt ? s_lo : s_hi);

	// Normalize the sum in every case
	wire [6:0] add_lz = fam_lzc48(add_mag[47:0]);
	wire [47:0] add_shl = add_mag[47:0] << add_lz;
	wire [47:0] add_coef = add_mag[48] ? add_mag[48:1] : add_shl;
	wire signed [17:0] add_e = add_mag[48] ? e18(e_hi) + 18'sh1 : e18(e_hi) - e18({8'h0, add_lz});
	wire add_ovf = a_ovf | b_ovf | (add_e >= e18(EXP_OVF));
	wire add_zero = (add_mag == 49'h0) | (add_e < e18(EXP_UNF));
	wire [63:0] add_res = add_ovf ? {add_s, EXP_SIG_ADD, add_coef} :
		add_zero ? 64'h0 : {add_s, add_e[14:0], add_coef};

	// Float to integer: shift by unbiased exponent
	wire fix_small = ea < EXP_BIAS;
	wire [14:0] fix_n = ea - EXP_BIAS;
	wire fix_err = !fix_small && (fix_n > 15'(COEF_W));
	wire [5:0] fix_sh = 6'(COEF_W) - fix_n[5:0];
	wire [47:0] fix_mag = ca >> fix_sh;
	wire [63:0] fix_int = {16'h0, fix_mag};
	wire [63:0] fix_val = sa ? -fix_int : fix_int;
	wire [63:0] fix_res = (fix_small || fix_err) ? 64'h0 : fix_val;

	// Integer to float: low 48 bits as a signed value
	wire flt_neg = opnd_a[COEF_W-1];
	wire [47:0] flt_low = opnd_a[COEF_W-1:0];
	wire [47:0] flt_mag = flt_neg ? -flt_low : flt_low;
	wire [6:0] flt_lz = fam_lzc48(flt_mag);
	wire [47:0] flt_coef = flt_mag << flt_lz;
	wire [14:0] flt_e = EXP_BIAS + 15'(COEF_W) - {8'h0, flt_lz};
	wire [63:0] flt_res = (flt_mag == 48'h0) ? 64'h0 : {flt_neg, flt_e, flt_coef};

	// Multiply array shared by product and reciprocal iteration
	wire [95:0] mul_prod = {48'h0, ca} * {48'h0, cb};
	wire mul_z = (ea == 15'h0) && (eb == 15'h0);
	wire signed [17:0] mul_es = e18(ea) + e18(eb) - e18(EXP_BIAS);

	// Keep eight bits below the result, round, then correct by one
	wire [MK:0] mul_rnd = {1'b0, mul_prod[2*COEF_W-1 -: MK]} + {{(MK-7){1'b0}}, MUL_ROUND};
	wire [47:0] mul_nc = mul_rnd[MK-1 -: COEF_W];
	wire [47:0] mul_coef = mul_rnd[MK] ? mul_rnd[MK -: COEF_W] :
		mul_rnd[MK-1] ? mul_nc : mul_rnd[MK-2 -: COEF_W];
	wire signed [17:0] mul_e = mul_rnd[MK] ? mul_es + 18'sh1 :
		mul_rnd[MK-1] ? mul_es : mul_es - 18'sh1;
	wire mul_ovf = !mul_z && (a_ovf || b_ovf || (mul_e >= e18(EXP_OVF)));
	wire mul_unf = mul_e < e18(EXP_UNF);
	wire mul_s = sa ^ sb;
	wire [63:0] mul_res = mul_z ? {16'h0, mul_nc} :
		mul_ovf ? {mul_s, EXP_SIG_MUL, mul_coef} :
		mul_unf ? 64'h0 : {mul_s, mul_e[14:0], mul_coef};

	// Reciprocal approximation: table seed, one pass through the array
	logic [18:0] rcp_two;
	logic [35:0] rcp_sq;

	fam_recip_seed #(
		.IDX_W(IDX_W)
	) u_seed (
		.idx(ca[COEF_W-1 -: IDX_W]),
		.two_a(rcp_two),
		.a_sq(rcp_sq)
	);

	wire [83:0] rcp_prod = {48'h0, rcp_sq} * {36'h0, ca};
	wire [83:0] rcp_r = {1'b0, rcp_two, 64'h0} - rcp_prod;
	wire [47:0] rcp_coef = rcp_r[81] ? rcp_r[81:34] :
		rcp_r[80] ? rcp_r[80:33] : rcp_r[79:32];
	wire signed [17:0] rcp_adj = rcp_r[81] ? 18'sh2 : rcp_r[80] ? 18'sh1 : 18'sh0;
	wire signed [17:0] rcp_e = e18(EXP_BIAS) + e18(EXP_BIAS) - e18(ea) + rcp_adj;
	wire rcp_bad = a_ovf || a_unf || (rcp_e >= e18(EXP_OVF));
	wire [63:0] rcp_res = rcp_bad ? {sa, EXP_SIG_RCP, rcp_coef} :
		{sa, rcp_e[14:0], rcp_coef};

	// Reciprocal iteration: 2 - a*b in a 98-bit fraction
	wire signed [17:0] itr_u = mul_es - e18(EXP_BIAS);
	wire [97:0] itr_v = (itr_u == 18'sh1) ? {1'b0, mul_prod, 1'b0} :
		(itr_u == 18'sh0) ? {2'h0, mul_prod} :
		(itr_u == -18'sh1) ? {3'h0, mul_prod[95:1]} : 98'h0;
	wire [97:0] itr_r = {1'b1, 97'h0} - itr_v;
	wire [6:0] itr_lz = fam_lzc48(itr_r[97:50]);
	wire [97:0] itr_sh = itr_r << itr_lz;
	wire [47:0] itr_coef = itr_sh[97:50];
	wire signed [17:0] itr_e = e18(EXP_BIAS) + 18'sh2 - e18({8'h0, itr_lz});
	wire itr_bad = a_ovf || b_ovf;
	wire [63:0] itr_res = itr_bad ? {1'b0, EXP_SIG_MUL, itr_coef} :
		(itr_r[97:50] == 48'h0) ? 64'h0 : {1'b0, itr_e[14:0], itr_coef};

	// Operation select
	wire op_add = (issue_op == FAM_OP_FADD) || (issue_op == FAM_OP_FSUB);
	wire op_mulu = (issue_op == FAM_OP_FMUL) || (issue_op == FAM_OP_RCP) || (issue_op == FAM_OP_RITER);
	wire resv_busy = resv_reg != 3'h0;
	wire accept = issue_valid && issue_ready;

	assign issue_ready = !(op_mulu && resv_busy);

	wire [63:0] sel_res =
		(issue_op == FAM_OP_IADD32) ? {32'h0, ia32} :
		(issue_op == FAM_OP_ISUB32) ? {32'h0, is32} :
		(issue_op == FAM_OP_IMUL32) ? {32'h0, im32} :
		(issue_op == FAM_OP_IADD64) ? ia64 :
		(issue_op == FAM_OP_ISUB64) ? is64 :
		op_add ? add_res :
		(issue_op == FAM_OP_FIX) ? fix_res :
		(issue_op == FAM_OP_FLT) ? flt_res :
		(issue_op == FAM_OP_FMUL) ? mul_res :
		(issue_op == FAM_OP_RCP) ? rcp_res :
		(issue_op == FAM_OP_RITER) ? itr_res : 64'h0;

	// Range error before gating; flt never errors
	wire err_raw =
		(op_add && add_ovf) ||
		((issue_op == FAM_OP_FIX) && fix_err) ||
		((issue_op == FAM_OP_FMUL) && mul_ovf) ||
		((issue_op == FAM_OP_RCP) && rcp_bad) ||
		((issue_op == FAM_OP_RITER) && itr_bad);

	assign result_next = accept ? sel_res : result_reg;
	assign err_next = accept && err_raw && range_err_en;

	// Scalar reciprocal approximation reserves the multiplier
	assign resv_next = (accept && (issue_op == FAM_OP_RCP)) ? 3'(RESV_CP - 1) :
		resv_busy ? resv_reg - 3'h1 : resv_reg;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			result_reg <= 64'h0;
			valid_reg <= 1'b0;
			err_reg <= 1'b0;
			resv_reg <= 3'h0;
		end else begin
			result_reg <= result_next;
			valid_reg <= accept;
			err_reg <= err_next;
			resv_reg <= resv_next;
		end
	end

	assign result = result_reg;
	assign result_valid = valid_reg;
	assign range_err = err_reg;

endmodule : fam_datapath

// file: rtl/fam_pkg.sv
// Constants and operation codes shared by the float add/multiply datapath
// Assumes the processor word is 64 bits and the issue logic uses fam_op_e
package fam_pkg;

	// Word layout
	localparam int FP_W = 64;
	localparam int SIGN_POS = 63;
	localparam int EXP_LSB = 48;
	localparam int EXP_W = 15;
	localparam int COEF_W = 48;

	// Integer widths
	localparam int INT_NARROW_W = 32;
	localparam int INT_W = 64;

	// Biased exponent values
	localparam logic [14:0] EXP_BIAS = 15'h4000;
	localparam logic [14:0] EXP_POS_MAX = 15'h5fff;
	localparam logic [14:0] EXP_NEG_MAX = 15'h3fff;
	localparam logic [14:0] EXP_OVF = 15'h6000;
	localparam logic [14:0] EXP_UNF = 15'h2000;

	// Overflow signature exponents
	localparam logic [14:0] EXP_SIG_ADD = 15'h6000;
	localparam logic [14:0] EXP_SIG_MUL = 15'h6001;
	localparam logic [14:0] EXP_SIG_RCP = 15'h6002;
	localparam logic [14:0] EXP_SIG_RSQ = 15'h6004;

	// Multiplier truncation and rounding
	localparam int MUL_GUARD = 8;
	localparam logic [7:0] MUL_ROUND = 8'h80;

	// Reciprocal seed table index width and iteration accuracy
	localparam int RCP_IDX_W = 12;
	localparam int RCP_ITER_BITS = 46;

	// Multiplier hold after a scalar reciprocal approximation, in clocks
	localparam int RESV_CP = 4;

	typedef enum logic [3:0] {
		FAM_OP_IADD32,
		FAM_OP_ISUB32,
		FAM_OP_IMUL32,
		FAM_OP_IADD64,
		FAM_OP_ISUB64,
		FAM_OP_FADD,
		FAM_OP_FSUB,
		FAM_OP_FIX,
		FAM_OP_FLT,
		FAM_OP_FMUL,
		FAM_OP_RCP,
		FAM_OP_RITER
	} fam_op_e;

endpackage : fam_pkg

// file: rtl/fam_recip_seed.sv
// Reciprocal seed table: 2A and A*A for the high coefficient bits
// Assumes a normalized coefficient; entries with a clear top index bit are zero
`timescale 1ns/10ps

module fam_recip_seed import fam_pkg::*; #(
	parameter int IDX_W = RCP_IDX_W
) (
	// Lookup
	input wire logic [IDX_W-1:0] idx,
	output logic [18:0] two_a,
	output logic [35:0] a_sq
);

	logic [18:0] two_tbl [2**IDX_W];
	logic [35:0] sq_tbl [2**IDX_W];

	// A scaled by 2^16, taken at the middle of each index interval
	for (genvar g = 0; g < 2**IDX_W; g++) begin : g_ent
		localparam longint AQ = (g < 2**(IDX_W-1)) ? 0 : (longint'(1) << (IDX_W + 17)) / (2 * g + 1);
		assign two_tbl[g] = 19'(AQ * 2);
		assign sq_tbl[g] = 36'(AQ * AQ);
	end

	assign two_a = two_tbl[idx];
	assign a_sq = sq_tbl[idx];

endmodule : fam_recip_seed

// file: dv/fam_datapath_assertions.sv
// Port checker for the float add/multiply datapath
// Assumes binding to fam_datapath; watches what the design drives
`timescale 1ns/10ps
module fam_datapath_assertions import fam_pkg::*; (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Issue
	input wire logic issue_valid,
	input wire fam_op_e issue_op,
	input wire logic [FP_W-1:0] opnd_a,
	input wire logic [FP_W-1:0] opnd_b,
	input wire logic issue_ready,
	input wire logic range_err_en,
	// Result
	input wire logic result_valid,
	input wire logic [FP_W-1:0] result,
	input wire logic range_err
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	wire acc = issue_valid & issue_ready;
	wire mul_op = issue_op inside {FAM_OP_FMUL, FAM_OP_RCP, FAM_OP_RITER};
	wire add_op = issue_op inside {FAM_OP_FADD, FAM_OP_FSUB};
	wire [14:0] ea = opnd_a[62:48];
	wire [14:0] eb = opnd_b[62:48];
	wire [14:0] er = result[62:48];
	sequence rcp_taken;
		acc && issue_op == FAM_OP_RCP;
	endsequence
	sequence mul_held;
		(!mul_op || !issue_ready) [*3];
	endsequence
	chk_take_answer: assert property (acc |=> result_valid) else $error("no result after take");
	chk_no_spurious: assert property (!acc |=> !result_valid) else $error("result without take");
	chk_err_gate: assert property (range_err |-> result_valid && $past(range_err_en))
		else $error("error pulse not gated");
	chk_rcp_hold: assert property (rcp_taken |=> mul_held) else $error("multiplier not held");
	chk_rcp_free: assert property (rcp_taken |-> ##4 issue_ready) else $error("multiplier held too long");
	chk_other_ready: assert property (!mul_op |-> issue_ready) else $error("non multiply op refused");
	chk_add_sig: assert property (acc && add_op && (ea >= EXP_OVF || eb >= EXP_OVF) |=>
		er == EXP_SIG_ADD && range_err == $past(range_err_en)) else $error("add overflow signature");
	chk_mul_sig: assert property (acc && issue_op == FAM_OP_FMUL && (ea >= EXP_OVF || eb >= EXP_OVF) |=>
		er == EXP_SIG_MUL && range_err == $past(range_err_en)) else $error("multiply overflow signature");
	chk_rcp_sig: assert property (acc && issue_op == FAM_OP_RCP && (ea >= EXP_OVF || ea < EXP_UNF) |=>
		er == EXP_SIG_RCP && range_err == $past(range_err_en)) else $error("reciprocal signature");
	chk_add_norm: assert property (result_valid && $past(acc && add_op) && er != EXP_SIG_ADD |->
		result == 64'h0 || result[47]) else $error("add result not normalized");
	chk_add_zero: assert property (acc && issue_op == FAM_OP_FSUB && opnd_a == opnd_b && ea < EXP_OVF |=>
		result == 64'h0) else $error("zero difference not all zero");
endmodule : fam_datapath_assertions

bind fam_datapath fam_datapath_assertions chk_u (.mclk, .reset, .issue_valid, .issue_op, .opnd_a, .opnd_b,
	.issue_ready, .range_err_en, .result_valid, .result, .range_err);

// file: dv/fam_issuer.sv
// Issue-side model: hands one operation at a time to the datapath
// Assumes a request is taken at a rising edge while issue_ready is high
`timescale 1ns/10ps
module fam_issuer import fam_pkg::*; (
	// Clock
	input wire logic mclk,
	// Issue
	output logic issue_valid,
	output fam_op_e issue_op,
	output logic [FP_W-1:0] opnd_a,
	output logic [FP_W-1:0] opnd_b,
	input wire logic issue_ready
);
	initial begin
		issue_valid = 1'b0;
		issue_op = FAM_OP_FADD;
		opnd_a = 64'h0;
		opnd_b = 64'h0;
	end
	// Called just after an edge; returns just after the taking edge
	task automatic issue(input fam_op_e op, input logic [63:0] a, input logic [63:0] b, input int gap,
		output int waits);
		waits = 0;
		if (gap > 0) begin
			issue_valid = 1'b0;
			repeat (gap) begin
				opnd_a = ~opnd_a;
				opnd_b = ~opnd_b;
				@(posedge mclk);
				#1;
			end
		end
		issue_op = op;
		opnd_a = a;
		opnd_b = b;
		issue_valid = 1'b1;
		#1;
		// Refused requests are held for up to 20 clocks, then dropped
		while (!issue_ready && waits < 20) begin
			@(posedge mclk);
			#1;
			waits++;
		end
		@(posedge mclk);
		#1;
	endtask : issue
endmodule : fam_issuer

// file: dv/test_float_add_multiply_datapath.sv
// Self-checking bench for the float add/multiply datapath
// Assumes fam_issuer stands in for the issue logic
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module test_float_add_multiply_datapath import fam_pkg::*; ;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic range_err_en = 1'b0;
	logic issue_valid, issue_ready, result_valid, range_err;
	fam_op_e issue_op;
	logic [FP_W-1:0] opnd_a, opnd_b, result;
	int failures = 0;
	int n_tests = 0;
	int w;
	logic [19:0] s, t;
	logic [63:0] x, y, r0;
	always #20 mclk = ~mclk;
	fam_issuer iss_u (.mclk, .issue_valid, .issue_op, .opnd_a, .opnd_b, .issue_ready);
	fam_datapath dut_u (.mclk, .reset, .issue_valid, .issue_op, .opnd_a, .opnd_b, .issue_ready, .range_err_en,
		.result_valid, .result, .range_err);
	function automatic logic [63:0] flt(input logic [47:0] v);
		logic [47:0] m;
		int p;
		m = v[47] ? -v : v;
		if (m == 48'h0) return 64'h0;
		p = 47;
		while (!m[p]) p--;
		return {v[47], 15'h4000 + 15'(p + 1), m << (47 - p)};
	endfunction : flt
	function automatic logic [63:0] mexp(input logic [47:0] a, input logic [47:0] b);
		logic [63:0] fa, fb, r;
		logic [95:0] pp;
		fa = flt(a);
		fb = flt(b);
		pp = {48'h0, fa[47:0]} * {48'h0, fb[47:0]};
		r = flt(a * b);
		// Round bit lands in the low coefficient bit after the left correction shift
		if (r != 64'h0 && !pp[95]) r[0] = 1'b1;
		return r;
	endfunction : mexp
	function automatic logic [63:0] iexp(input fam_op_e op, input logic [63:0] a, input logic [63:0] b);
		case (op)
			FAM_OP_IADD32: return {32'h0, a[31:0] + b[31:0]};
			FAM_OP_ISUB32: return {32'h0, a[31:0] - b[31:0]};
			FAM_OP_IMUL32: return {32'h0, a[31:0] * b[31:0]};
			FAM_OP_IADD64: return a + b;
			default: return a - b;
		endcase
	endfunction : iexp
	function automatic logic near_one(input logic [63:0] p);
		if (p[63:48] == 16'h4001) return p[47:0] - 48'h800000000000 < 48'h80;
		return p[63:48] == 16'h4000 && 48'h0 - p[47:0] < 48'h80;
	endfunction : near_one
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : end_sim
	task automatic run(input fam_op_e op, input logic [63:0] a, input logic [63:0] b, input int gap);
		iss_u.issue(op, a, b, gap, w);
		if (w >= 20) begin
			failures++;
			end_sim();
		end
		`CHK("valid", 1'b1, result_valid)
	endtask : run
	initial begin
		void'($urandom(32'h3e1b));
		repeat (6) @(posedge mclk);
		#1;
		reset = 1'b0;
		`CHK("reset result", 65'h0, {result_valid, result})
		for (int i = 0; i < 20; i++) begin
			x = {$urandom, $urandom};
			y = {$urandom, $urandom};
			run(fam_op_e'(i % 5), x, y, i % 2);
			`CHK("integer", iexp(fam_op_e'(i % 5), x, y), result)
		end
		$display("test integer done");
		for (int i = 0; i < 10; i++) begin
			s = 20'($urandom);
			t = (i == 0) ? s : 20'($urandom);
			x = 64'(signed'(s));
			y = 64'(signed'(t));
			run(FAM_OP_FLT, {16'($urandom), x[47:0]}, 64'h0, 0);
			`CHK("flt", flt(x[47:0]), result)
			run(FAM_OP_FIX, flt(x[47:0]), 64'h0, 0);
			`CHK("fix", x, result)
			run(FAM_OP_FADD, flt(x[47:0]), flt(y[47:0]), 0);
			`CHK("add", flt(x[47:0] + y[47:0]), result)
			run(FAM_OP_FSUB, flt(x[47:0]), flt(y[47:0]), 1);
			`CHK("sub", flt(x[47:0] - y[47:0]), result)
			run(FAM_OP_FADD, {1'b0, 15'h4030, 28'h0, s}, {1'b0, 15'h1fff, 48'h800000000000}, 0);
			`CHK("unnorm add", flt({28'h0, s}), result)
			run(FAM_OP_FMUL, flt(x[47:0]), flt(y[47:0]), 0);
			`CHK("mul", mexp(x[47:0], y[47:0]), result)
			run(FAM_OP_FMUL, {1'b1, 15'h0, 48'h800000000000}, {16'h0, 27'h0, t, 1'b0}, 0);
			`CHK("mul raw", {44'h0, t}, result)
			x = flt({28'h0, s | 20'h1});
			run(FAM_OP_RCP, x, 64'h0, 0);
			r0 = result;
			run(FAM_OP_RITER, x, r0, 0);
			`CHK("hold", RESV_CP - 1, w)
			run(FAM_OP_FMUL, r0, result, 0);
			run(FAM_OP_FMUL, x, result, 0);
			`CHK("recip", 1'b1, near_one(result))
		end
		$display("test float done");
		for (int e = 0; e < 2; e++) begin
			range_err_en = e[0];
			run(FAM_OP_FADD, {1'b0, EXP_OVF, 48'h800000000000}, flt(48'd1), 0);
			`CHK("add ovf", {e[0], EXP_SIG_ADD}, {range_err, result[62:48]})
			run(FAM_OP_FMUL, {1'b0, e ? EXP_OVF : 15'h5fff, 48'h800000000000}, {1'b1, 15'h5fff, 48'h800000000000}, 0);
			`CHK("mul ovf", {e[0], EXP_SIG_MUL}, {range_err, result[62:48]})
			run(FAM_OP_RCP, {1'b0, e ? 15'h1fff : EXP_OVF, 48'h800000000000}, 64'h0, 0);
			`CHK("rcp range", {e[0], EXP_SIG_RCP}, {range_err, result[62:48]})
			run(FAM_OP_FIX, {1'b0, 15'h4031, 48'h800000000000}, 64'h0, 0);
			`CHK("fix ovf", {e[0], 64'h0}, {range_err, result})
			run(FAM_OP_FMUL, {1'b0, EXP_UNF, 48'h800000000000}, {1'b1, EXP_UNF, 48'h800000000000}, 0);
			`CHK("mul unf", 65'h0, {range_err, result})
		end
		$display("test range done");
		end_sim();
	end
endmodule : test_float_add_multiply_datapath
